//--- core/agal_core.sv
// Purpose: Operand address generation, alignment, bit operations and program counter.
// Assumes: Bus answers with bus_ack; misalign strap is an asynchronous pin.
// Notes: An unaligned access with misalign enabled is split into two bus beats.
// How it works
// (RULE1) Multi-byte data is little endian with byte 0 least significant at the lowest address.
// (RULE2) A word at A covers A to A+3, and its low two address bits are zeroed when misalign is off.
// (RULE3) A halfword at A covers A and A+1, and its low address bit is zeroed when misalign is off.
// (RULE4) A bit operand is a byte address plus a three-bit bit number within that byte.
// (RULE5) Loads sign-extend or zero-extend 8 and 16 bit data to 32 bits as signedness asks.
// (RULE6) With misalign off the low address bits are masked before the access is issued.
// (RULE7) With misalign on any byte address is accepted and an unaligned access takes an extra beat.
// (RULE8) The misalign mode follows the level on the synchronised misalign enable pin.
// (RULE9) Full 32-bit operand addresses are driven over a linear 4 GB space.
// (RULE10) Instruction addresses are held in a 26-bit counter covering 64 MB.
// (RULE11) Without a branch the counter advances by the instruction length in steps of two.
// (RULE12) Relative branches add a sign-extended 9 or 22 bit displacement to the counter.
// (RULE13) Bit operations touch one byte and are set, clear, invert or test.
// (RULE14) Memory and I/O share the one operand space with no separate I/O strobe.
// (RULE15) Bit 0 of every branch target is forced to zero.
`timescale 1ns/1ps
`default_nettype none
module agal_core
   import agal_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic misalign_enable_pin,
   input wire logic req_valid,
   input wire logic req_write,
   input wire agal_size_t req_size,
   input wire logic req_signed,
   input wire agal_bitop_t req_bitop,
   input wire logic [2:0] req_bitnum,
   input wire logic [31:0] req_addr,
   input wire logic [31:0] req_wdata,
   output logic req_ready,
   output logic resp_valid,
   output logic [31:0] resp_data,
   output logic resp_bit,
   output logic bus_req,
   output logic bus_write,
   output logic [31:0] bus_addr,
   output logic [3:0] bus_be,
   output logic [31:0] bus_wdata,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata,
   input wire logic pc_step,
   input wire agal_pcop_t pc_op,
   input wire logic pc_long,
   input wire logic [21:0] pc_disp,
   output logic [25:0] pc_out
);
   typedef enum logic [2:0] {AGAL_IDLE, AGAL_BEAT0, AGAL_BEAT1, AGAL_BWRITE, AGAL_DONE} agal_state_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte mask of an access size, placed at lane 0.
   function automatic logic [7:0] size_mask(input agal_size_t sz);
      case (sz)
         AGAL_SZ_WORD: size_mask = 8'h0F;
         AGAL_SZ_HALF: size_mask = 8'h03;
         default: size_mask = 8'h01;
      endcase
   endfunction : size_mask

   // True when the access is unaligned and so needs a second beat.
   // An odd halfword inside one word still spends that beat, with no lanes enabled, to keep the extra cycle.
   function automatic logic crosses(input agal_size_t sz, input logic [1:0] off);
      logic [7:0] m;
      m = size_mask(sz) << off;
      crosses = |m[7:4] || (sz == AGAL_SZ_HALF && off[0]);
   endfunction : crosses

   ////////////////////////////////////////////////////////////////////////////////
   // The first flop only feeds the second, as the pin is asynchronous.
   logic mis_meta_reg;
   logic mis_sync_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mis_meta_reg <= 1'b0;
         mis_sync_reg <= 1'b0;
      end else begin
         mis_meta_reg <= misalign_enable_pin;
         mis_sync_reg <= mis_meta_reg; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   agal_state_t state_reg;
   logic write_reg;
   logic signed_reg;
   agal_size_t size_reg;
   agal_bitop_t bitop_reg;
   logic [2:0] bitnum_reg;
   logic [31:0] addr_reg;
   logic [31:0] wdata_reg;
   logic [31:0] rdata_reg;
   logic split_reg;

   logic [31:0] eff_addr;
   always_comb begin
      eff_addr = req_addr; // RULE9 RULE14
      if (!mis_sync_reg) begin
         if (req_size == AGAL_SZ_WORD) begin
            eff_addr[1:0] = 2'b00; // RULE2 RULE6
         end else if (req_size == AGAL_SZ_HALF) begin
            eff_addr[0] = 1'b0; // RULE3 RULE6
         end
      end
   end

   agal_lane_if lane ();
   agal_lane_shift u_shift (.lane(lane));

   logic [7:0] full_be;
   logic [31:0] word_addr;
   logic [31:0] byte_val;
   always_comb begin
      full_be = size_mask(size_reg) << addr_reg[1:0];
      word_addr = {addr_reg[31:2], 2'b00};
      lane.offset = addr_reg[1:0];
      lane.wdata_in = wdata_reg;
      lane.rdata_in = rdata_reg;
   end

   // The target byte is taken from the shifted read data, since the bus word holds it in its own lane.
   always_comb begin
      byte_val = {24'h000000, lane.rdata_out[7:0]};
      case (bitop_reg)
         AGAL_BIT_SET: byte_val[bitnum_reg] = 1'b1; // RULE4 RULE13
         AGAL_BIT_CLEAR: byte_val[bitnum_reg] = 1'b0; // RULE13
         AGAL_BIT_INVERT: byte_val[bitnum_reg] = ~lane.rdata_out[bitnum_reg]; // RULE13
         default: byte_val[bitnum_reg] = lane.rdata_out[bitnum_reg];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Request capture and sequencing.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= AGAL_IDLE;
         write_reg <= 1'b0;
         signed_reg <= 1'b0;
         size_reg <= AGAL_SZ_BYTE;
         bitop_reg <= AGAL_BIT_TEST;
         bitnum_reg <= 3'h0;
         addr_reg <= ADDR_RESET;
         wdata_reg <= 32'h0000_0000;
         split_reg <= 1'b0;
      end else begin
         case (state_reg)
            AGAL_IDLE: begin
               if (req_valid) begin
                  write_reg <= req_write;
                  signed_reg <= req_signed;
                  size_reg <= req_size;
                  bitop_reg <= req_bitop;
                  bitnum_reg <= req_bitnum;
                  addr_reg <= eff_addr;
                  wdata_reg <= req_wdata;
                  split_reg <= crosses(req_size, eff_addr[1:0]); // RULE7
                  state_reg <= AGAL_BEAT0;
               end
            end
            AGAL_BEAT0: begin
               if (bus_ack) begin
                  if (split_reg) begin
                     state_reg <= AGAL_BEAT1; // RULE7
                  end else if (size_reg == AGAL_SZ_BIT && bitop_reg != AGAL_BIT_TEST) begin
                     state_reg <= AGAL_BWRITE; // RULE13
                  end else begin
                     state_reg <= AGAL_DONE;
                  end
               end
            end
            AGAL_BEAT1: begin
               if (bus_ack) begin
                  state_reg <= AGAL_DONE;
               end
            end
            AGAL_BWRITE: begin
               if (bus_ack) begin
                  state_reg <= AGAL_DONE;
               end
            end
            AGAL_DONE: state_reg <= AGAL_IDLE;
            default: state_reg <= AGAL_IDLE;
         endcase
      end
   end

   // A split read is gathered into operand order, the second beat supplying the high lanes.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (state_reg == AGAL_IDLE && req_valid) begin
         rdata_reg <= 32'h0000_0000;
      end else if (state_reg == AGAL_BEAT0 && bus_ack && !write_reg) begin
         rdata_reg <= bus_rdata; // RULE1
      end else if (state_reg == AGAL_BEAT1 && bus_ack && !write_reg) begin
         rdata_reg <= lane.rdata_out | (bus_rdata << {3'(3'd4 - {1'b0, addr_reg[1:0]}), 3'b000}); // RULE1 RULE7
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus drive, registered so that every output comes from a flop.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_req <= 1'b0;
         bus_write <= 1'b0;
         bus_addr <= ADDR_RESET;
         bus_be <= 4'h0;
         bus_wdata <= 32'h0000_0000;
      end else begin
         bus_req <= 1'b0;
         if ((state_reg == AGAL_BEAT0 || state_reg == AGAL_BEAT1 || state_reg == AGAL_BWRITE) && !bus_ack) begin
            bus_req <= 1'b1;
            bus_write <= write_reg || state_reg == AGAL_BWRITE;
            if (state_reg == AGAL_BEAT1) begin
               bus_addr <= word_addr + 32'h0000_0004; // RULE7
               bus_be <= full_be[7:4];
               bus_wdata <= wdata_reg >> {3'(3'd4 - {1'b0, addr_reg[1:0]}), 3'b000};
            end else if (state_reg == AGAL_BWRITE) begin
               bus_addr <= addr_reg; // RULE13
               bus_be <= full_be[3:0];
               bus_wdata <= byte_val << {addr_reg[1:0], 3'b000};
            end else begin
               bus_addr <= (size_reg == AGAL_SZ_BIT || size_reg == AGAL_SZ_BYTE) ? addr_reg : word_addr;
               bus_be <= full_be[3:0];
               bus_wdata <= lane.wdata_out;
            end
         end
      end
   end

   // A one-beat read arrives in lane order and is shifted down on completion.
   logic [31:0] op_val;
   always_comb begin
      op_val = split_reg ? rdata_reg : lane.rdata_out;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         resp_valid <= 1'b0;
         resp_data <= 32'h0000_0000;
         resp_bit <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         resp_valid <= state_reg == AGAL_DONE;
         req_ready <= state_reg == AGAL_IDLE && !req_valid;
         if (state_reg == AGAL_DONE) begin
            resp_bit <= op_val[bitnum_reg]; // RULE4 RULE13
            case (size_reg)
               AGAL_SZ_HALF: resp_data <= {{16{signed_reg & op_val[15]}}, op_val[15:0]}; // RULE5
               AGAL_SZ_WORD: resp_data <= op_val; // RULE5
               default: resp_data <= {{24{signed_reg & op_val[7]}}, op_val[7:0]}; // RULE5
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Program counter.
   logic [25:0] disp_ext;
   always_comb begin
      if (pc_op == AGAL_PC_REL9) begin
         disp_ext = {{17{pc_disp[8]}}, pc_disp[8:0]}; // RULE12
      end else begin
         disp_ext = {{4{pc_disp[21]}}, pc_disp}; // RULE12
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pc_out <= PC_RESET;
      end else if (pc_step) begin
         case (pc_op)
            AGAL_PC_SEQ: pc_out <= pc_out + (pc_long ? 26'(PC_STEP << 1) : PC_STEP); // RULE10 RULE11
            AGAL_PC_REL9, AGAL_PC_REL22: pc_out <= (pc_out + disp_ext) & 26'h3FF_FFFE; // RULE12 RULE15
            default: pc_out <= pc_out;
         endcase
      end
   end
endmodule : agal_core
`default_nettype wire

//--- common/agal_pkg.sv
// Purpose: Shared constants and types for the address generation and alignment block.
// Assumes: 32-bit operand addresses, halfword-aligned instruction addresses.
// Notes: Counts and reset values live here so that every file uses one name.
package agal_pkg;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PC_W = 26;
   localparam int unsigned DISP9_W = 9;
   localparam int unsigned DISP22_W = 22;
   localparam int unsigned BITNUM_W = 3;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [25:0] PC_RESET = 26'h000_0000;
   localparam logic [25:0] PC_STEP = 26'h000_0002;

   typedef enum logic [1:0] {
      AGAL_SZ_BYTE,
      AGAL_SZ_HALF,
      AGAL_SZ_WORD,
      AGAL_SZ_BIT
   } agal_size_t;

   typedef enum logic [1:0] {
      AGAL_BIT_SET,
      AGAL_BIT_CLEAR,
      AGAL_BIT_INVERT,
      AGAL_BIT_TEST
   } agal_bitop_t;

   typedef enum logic [1:0] {
      AGAL_PC_SEQ,
      AGAL_PC_REL9,
      AGAL_PC_REL22,
      AGAL_PC_HOLD
   } agal_pcop_t;
endpackage : agal_pkg

//--- common/agal_lane_if.sv
// Purpose: Carries one byte-lane beat between the sequencer and the lane shifter.
// Assumes: Single clock domain.
// Notes: The sequencer drives the request side, the shifter answers combinationally.
`timescale 1ns/1ps
`default_nettype none
interface agal_lane_if;
   logic [1:0] offset;
   logic [31:0] wdata_in;
   logic [31:0] rdata_in;
   logic [31:0] wdata_out;
   logic [31:0] rdata_out;
   modport seq (output offset, output wdata_in, output rdata_in, input wdata_out, input rdata_out);
   modport shf (input offset, input wdata_in, input rdata_in, output wdata_out, output rdata_out);
endinterface : agal_lane_if
`default_nettype wire

//--- core/agal_lane_shift.sv
// Purpose: Moves bytes between operand order and bus lane order.
// Assumes: Little-endian lanes, lane 0 at the lowest address.
// Notes: Pure combinational shifter used for every first write beat, for one-beat reads and bit operations, and for the second read beat of a split access.
`timescale 1ns/1ps
`default_nettype none
module agal_lane_shift (
   agal_lane_if.shf lane
);
   // Write data is shifted up to the lane of the address; read data shifted down.
   always_comb begin
      lane.wdata_out = lane.wdata_in << {lane.offset, 3'b000}; // RULE1
      lane.rdata_out = lane.rdata_in >> {lane.offset, 3'b000}; // RULE1
   end
endmodule : agal_lane_shift
`default_nettype wire

//--- test/agal_core_checker.sv
// Purpose: Port assertions for agal_core.
// Assumes: The misalign pin is steady around each request.
// Notes: Beat counting covers split and bit accesses.
`timescale 1ns/1ps
`default_nettype none
module agal_core_checker
   import agal_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic misalign_enable_pin,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire agal_size_t req_size,
   input wire agal_bitop_t req_bitop,
   input wire logic [31:0] req_addr,
   input wire logic resp_valid,
   input wire logic bus_req,
   input wire logic bus_write,
   input wire logic [31:0] bus_addr,
   input wire logic [3:0] bus_be,
   input wire logic bus_ack,
   input wire logic pc_step,
   input wire agal_pcop_t pc_op,
   input wire logic [21:0] pc_disp,
   input wire logic pc_long,
   input wire logic [25:0] pc_out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic take;
   logic split;
   logic [1:0] beats_reg;
   logic [1:0] need_reg;
   assign take = req_valid && req_ready;
   // A read-modify-write or a split access costs two beats, anything else one.
   assign split = req_size == AGAL_SZ_BIT ? req_bitop != AGAL_BIT_TEST : misalign_enable_pin &&
      (req_size == AGAL_SZ_WORD ? req_addr[1:0] != 2'h0 : req_size == AGAL_SZ_HALF && req_addr[0]);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         beats_reg <= 2'h0;
         need_reg <= 2'h1;
      end else if (take) begin
         beats_reg <= 2'h0;
         need_reg <= split ? 2'h2 : 2'h1;
      end else if (bus_req && bus_ack) begin
         beats_reg <= beats_reg + 2'h1;
      end
   end
////////////////////////////////////////
   property p_word; take && !misalign_enable_pin && req_size == AGAL_SZ_WORD |-> ##2 bus_req &&
      bus_be == 4'hF && bus_addr == {$past(req_addr[31:2], 2), 2'h0}; endproperty
   a_word: assert property (p_word) else $error("word address not masked");
   property p_half; take && !misalign_enable_pin && req_size == AGAL_SZ_HALF |-> ##2 bus_req &&
      bus_be == ($past(req_addr[1], 2) ? 4'hC : 4'h3); endproperty
   a_half: assert property (p_half) else $error("halfword lanes wrong");
   property p_beats; resp_valid |-> beats_reg == need_reg; endproperty
   a_beats: assert property (p_beats) else $error("bus beat count wrong");
   property p_bitrd; take && req_size == AGAL_SZ_BIT |-> ##2 bus_req && !bus_write &&
      bus_be == 4'h1 << $past(req_addr[1:0], 2); endproperty
   a_bitrd: assert property (p_bitrd) else $error("bit access not a byte read");
   property p_seq; pc_step && pc_op == AGAL_PC_SEQ |=> pc_out == $past(pc_out) + ($past(pc_long) ? 26'h4 : 26'h2);
   endproperty
   a_seq: assert property (p_seq) else $error("sequential step wrong");
   property p_rel9; pc_step && pc_op == AGAL_PC_REL9 |=>
      pc_out == (($past(pc_out) + 26'($signed($past(pc_disp[8:0])))) & 26'h3FFFFFE); endproperty
   a_rel9: assert property (p_rel9) else $error("short branch target wrong");
   property p_rel22; pc_step && pc_op == AGAL_PC_REL22 |=>
      pc_out == (($past(pc_out) + 26'($signed($past(pc_disp)))) & 26'h3FFFFFE); endproperty
   a_rel22: assert property (p_rel22) else $error("long branch target wrong");
   property p_even; pc_out[0] == 1'b0; endproperty
   a_even: assert property (p_even) else $error("odd fetch address");
   c_split: cover property (resp_valid && need_reg == 2'h2);
   c_word: cover property (take && req_size == AGAL_SZ_WORD);
   c_rel22: cover property (pc_step && pc_op == AGAL_PC_REL22);
endmodule : agal_core_checker
bind agal_core agal_core_checker u_chk (.*);
`default_nettype wire

//--- test/agal_mem_model.sv
// Purpose: Memory and I/O bus partner for agal_core.
// Assumes: One beat per bus_req, closed by a one-cycle bus_ack.
// Notes: Unwritten bytes read as address xor 5A; latency alternates 0 and 3.
`timescale 1ns/1ps
`default_nettype none
module agal_mem_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic bus_req,
   input wire logic bus_write,
   input wire logic [31:0] bus_addr,
   input wire logic [3:0] bus_be,
   input wire logic [31:0] bus_wdata,
   output logic bus_ack,
   output logic [31:0] bus_rdata
);
   logic [7:0] mem [logic [31:0]];
   logic [1:0] wait_reg;
   logic slow_reg;
   logic [31:0] a;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_ack <= 1'b0;
         bus_rdata <= 32'h0;
         wait_reg <= 2'h0;
         slow_reg <= 1'b0;
      end else if (bus_req && !bus_ack && wait_reg == 2'h0) begin
         bus_ack <= 1'b1;
         slow_reg <= !slow_reg;
         wait_reg <= {2{slow_reg}};
         for (int k = 0; k < 4; k++) begin
            a = {bus_addr[31:2], 2'h0} + k;
            bus_rdata[8*k +: 8] <= mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5A;
            if (bus_write && bus_be[k]) mem[a] = bus_wdata[8*k +: 8];
         end
      end else begin
         bus_ack <= 1'b0;
         // Idle data lines scramble so that a late sample cannot pass by luck.
         bus_rdata <= ~bus_rdata;
         if (bus_req && !bus_ack) wait_reg <= wait_reg - 2'h1;
      end
   end
endmodule : agal_mem_model
`default_nettype wire

//--- test/tb_top.sv
// Purpose: Self-checking bench for agal_core.
// Assumes: Partner memory reads address xor 5A where unwritten.
// Notes: Bus timing is also judged by the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import agal_pkg::*;
;
   logic clock, rst, misalign_enable_pin, req_valid, req_write, req_signed, pc_step, pc_long;
   logic req_ready, resp_valid, resp_bit, bus_req, bus_write, bus_ack;
   agal_size_t req_size;
   agal_bitop_t req_bitop;
   agal_pcop_t pc_op;
   logic [2:0] req_bitnum;
   logic [31:0] req_addr, req_wdata, resp_data, bus_addr, bus_wdata, bus_rdata;
   logic [3:0] bus_be;
   logic [21:0] pc_disp;
   logic [25:0] pc_out;
   int num_checks = 0;
   int n_mismatch = 0;
   agal_core dut (.*);
   agal_mem_model u_mem (.*);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
////////////////////////////////////////
   task automatic chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   function automatic logic [31:0] xp(input logic [31:0] a, input int n, input logic sg);
      logic [31:0] v;
      v = 32'h0;
      for (int k = 0; k < n; k++) v[8*k +: 8] = (a[7:0] + k[7:0]) ^ 8'h5A;
      if (sg && v[8*n-1]) v = v | ~((32'h1 << (8*n)) - 32'h1);
      return v;
   endfunction : xp
   task automatic go(input logic w, agal_size_t sz, logic sg, agal_bitop_t op, logic [2:0] bn, logic [31:0] a, d);
      int i;
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= w;
      req_size <= sz;
      req_signed <= sg;
      req_bitop <= op;
      req_bitnum <= bn;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clock);
      req_valid <= 1'b0;
      for (i = 0; i < 100; i++) begin
         @(negedge clock);
         if (resp_valid === 1'b1) break;
      end
      if (i == 100) n_mismatch++;
   endtask : go
   task automatic ld(input agal_size_t sz, logic sg, logic [31:0] a, e);
      go(1'b0, sz, sg, AGAL_BIT_TEST, 3'h0, a, 32'h0);
      chk(resp_data, e);
   endtask : ld
   task automatic t_align;
      ld(AGAL_SZ_WORD, 1'b0, 32'h1003, xp(32'h1000, 4, 1'b0));
      ld(AGAL_SZ_HALF, 1'b1, 32'h10F5, xp(32'h10F4, 2, 1'b1));
      ld(AGAL_SZ_BYTE, 1'b1, 32'h10F5, xp(32'h10F5, 1, 1'b1));
      ld(AGAL_SZ_BYTE, 1'b0, 32'h10F5, xp(32'h10F5, 1, 1'b0));
      go(1'b1, AGAL_SZ_WORD, 1'b0, AGAL_BIT_TEST, 3'h0, 32'h4002, 32'h11223344);
      ld(AGAL_SZ_WORD, 1'b0, 32'h4000, 32'h11223344);
   endtask : t_align
   task automatic t_mis;
      @(posedge clock);
      misalign_enable_pin <= 1'b1;
      repeat (4) @(posedge clock);
      ld(AGAL_SZ_WORD, 1'b0, 32'h2001, xp(32'h2001, 4, 1'b0));
      ld(AGAL_SZ_HALF, 1'b1, 32'h20F7, xp(32'h20F7, 2, 1'b1));
      ld(AGAL_SZ_HALF, 1'b0, 32'h2011, xp(32'h2011, 2, 1'b0));
      ld(AGAL_SZ_BYTE, 1'b0, 32'hFFFFFFFF, xp(32'hFFFFFFFF, 1, 1'b0));
      go(1'b1, AGAL_SZ_WORD, 1'b0, AGAL_BIT_TEST, 3'h0, 32'h4005, 32'hA1B2C3D4);
      ld(AGAL_SZ_WORD, 1'b0, 32'h4005, 32'hA1B2C3D4);
      @(posedge clock);
      misalign_enable_pin <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : t_mis
   task automatic t_bit;
      agal_bitop_t op [5] = '{AGAL_BIT_SET, AGAL_BIT_TEST, AGAL_BIT_CLEAR, AGAL_BIT_TEST, AGAL_BIT_INVERT};
      logic [2:0] bn [5] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h7};
      logic ex [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      for (int k = 0; k < 5; k++) begin
         go(1'b0, AGAL_SZ_BIT, 1'b0, op[k], bn[k], 32'h3007, 32'h0);
         chk({31'h0, resp_bit}, {31'h0, ex[k]});
      end
      ld(AGAL_SZ_BYTE, 1'b0, 32'h3007, 32'hDD);
   endtask : t_bit
   task automatic t_pc;
      agal_pcop_t op [7] = '{AGAL_PC_SEQ, AGAL_PC_SEQ, AGAL_PC_REL9, AGAL_PC_REL9, AGAL_PC_HOLD,
         AGAL_PC_REL22, AGAL_PC_REL22};
      logic [21:0] d [7] = '{22'h0, 22'h0, 22'h2001FC, 22'hFF, 22'h0, 22'h3FFE00, 22'h101};
      logic [25:0] e [7] = '{26'h2, 26'h6, 26'h2, 26'h100, 26'h100, 26'h3FFFF00, 26'h0};
      for (int k = 0; k < 7; k++) begin
         @(posedge clock);
         pc_step <= 1'b1;
         pc_op <= op[k];
         pc_long <= k == 1;
         pc_disp <= d[k];
         @(posedge clock);
         pc_step <= 1'b0;
         @(negedge clock);
         chk(32'(pc_out), 32'(e[k]));
      end
   endtask : t_pc
   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      stop_test();
   end
   initial begin
      {rst, misalign_enable_pin, req_valid, req_write, req_signed, pc_step, pc_long} = 7'h40;
      {req_bitnum, req_addr, req_wdata, pc_disp} = 89'h0;
      req_size = AGAL_SZ_BYTE;
      req_bitop = AGAL_BIT_SET;
      pc_op = AGAL_PC_SEQ;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      t_pc();
      t_align();
      t_mis();
      t_bit();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
